// file: inc/prot_params.svh
// constants for the secondary protection supervisor
//
// Function
// - stay inactive until supply passes the turn-on threshold, nominally 4.5V
// - below turn-off threshold 4.25V shut down and reset all flags and counters
// - supply comparator change must persist about 10 us before acceptance
// - sense above overload level longer than overload delay sets overload flag
// - overload flag clears only on secondary or primary undervoltage lockout
// - compensation above max-frequency level runs overload timer, expiry trips overload
// - compensation node held at ground while overload flag is set
// - feedback above overvoltage level longer than delay sets overvoltage flag
// - overvoltage clears once feedback falls back to reference level
// - bleed current enabled while overvoltage flag is set
// - supply ready but feedback below open-loop level for validation time trips
// - 8 consecutive bad rectifier cycles trip gate-open; a good cycle restarts
// - gate-open protection holds until the primary controller restarts
// - at turn-on a gate pin under 1k ohm declares gate short until restart
// - 17 primary pulses without drain-triggered gate trip drain-abnormal protection
// - drain-abnormal clears on any lockout; after a primary lockout, resume only after valid drain signal
// - over-temperature flag latched until temperature falls by the hysteresis
// - peak comparator resets the drive flip-flop, gate drive low rest of cycle
`ifndef PROT_PARAMS_SVH
`define PROT_PARAMS_SVH
// ============================================================
// timing
`define CLK_PERIOD_NS 20
`define UV_QUAL_NS 10000
`define OLP_DELAY_NS 50000
`define OVP_DELAY_NS 20000
`define FBO_VALID_NS 40000
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 12
`define GATE_OPEN_CYCLES 4'h8
`define DRAIN_PULSES 5'h11
// ============================================================
// register port
`define ADDR_W 2
`define DATA_W 8
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_CAUSE 2'h2
`define CTRL_RESET 8'h03
`define CTRL_SENSE_BIT 0
`define CTRL_COMP_BIT 1
`endif

// file: inc/prot_pkg.sv
// types for the secondary protection supervisor
package prot_pkg;
  typedef enum logic {SUP_OFF, SUP_ON} supply_e;
  typedef logic [11:0] cnt_t;
endpackage : prot_pkg

// file: src/secondary_protection_supervisor.sv
// secondary-side protection supervisor with register port
`timescale 1ns/1ns
`include "prot_params.svh"
module secondary_protection_supervisor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [`DATA_W-1:0] rdata,
  input wire logic vdd_above_on,
  input wire logic vdd_below_off,
  input wire logic vdd_above_rdy,
  input wire logic sense_over_olp,
  input wire logic comp_over_fsmax,
  input wire logic fb_over_ovp,
  input wire logic fb_at_ref,
  input wire logic fb_below_open,
  input wire logic rectifier_gate_drive,
  input wire logic drain_above_gate_open,
  input wire logic gate_low_resistance,
  input wire logic primary_switch_pulse,
  input wire logic drain_trigger,
  input wire logic primary_restart,
  input wire logic primary_uvlo,
  input wire logic temp_over_trip,
  input wire logic temp_below_release,
  input wire logic drive_set,
  input wire logic peak_cmp,
  output logic controller_active,
  output logic overload_flag,
  output logic overvoltage_flag,
  output logic feedback_open_loop_protection,
  output logic gate_open_protection,
  output logic gate_short_protection,
  output logic drain_abnormal_protection,
  output logic secondary_overtemp_flag,
  output logic switching_enable,
  output logic comp_short_to_ground,
  output logic bleed_current_enable,
  output logic primary_gate_drive
);

  // ============================================================
  // helpers
  // set wins over clear so a coincident event is never lost
  function automatic logic latch_next(input logic set, input logic clr,
                                      input logic cur);
    latch_next = set | (cur & ~clr);
  endfunction : latch_next

  // ============================================================
  // supply lockout qualification
  prot_pkg::supply_e sup_ff;
  prot_pkg::supply_e nxt_sup;
  prot_pkg::cnt_t uv_cnt_ff;
  prot_pkg::cnt_t nxt_uv_cnt;
  wire logic sup_on;
  wire logic uv_want;
  wire logic uv_done;
  wire logic turn_on_evt;

  // the comparator wanting a change must hold through the whole count
  assign sup_on = (sup_ff == prot_pkg::SUP_ON);
  assign uv_want = sup_on ? vdd_below_off : vdd_above_on;
  assign uv_done = (uv_cnt_ff == prot_pkg::cnt_t'(`CYC_UP(`UV_QUAL_NS) - 1));
  assign nxt_uv_cnt = (!uv_want || uv_done) ? '0 : uv_cnt_ff + 1'b1;
  assign turn_on_evt = !sup_on && uv_want && uv_done;

  always_comb begin
    nxt_sup = sup_ff;
    case (sup_ff)
      prot_pkg::SUP_OFF: begin
        if (uv_want && uv_done) begin
          nxt_sup = prot_pkg::SUP_ON;
        end
      end
      prot_pkg::SUP_ON: begin
        if (uv_want && uv_done) begin
          nxt_sup = prot_pkg::SUP_OFF;
        end
      end
      default: begin
        nxt_sup = prot_pkg::SUP_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sup_ff <= prot_pkg::SUP_OFF;
      uv_cnt_ff <= '0;
    end else begin
      sup_ff <= nxt_sup;
      uv_cnt_ff <= nxt_uv_cnt;
    end
  end

  // ============================================================
  // register port
  logic [`DATA_W-1:0] ctrl_ff;
  logic [`DATA_W-1:0] rdata_ff;
  logic [`DATA_W-1:0] nxt_rdata;
  logic [`DATA_W-1:0] cause_ff;
  wire logic [`DATA_W-1:0] status_word;
  wire logic [`DATA_W-1:0] flag_word;

  assign flag_word = {sup_on, secondary_overtemp_flag, drain_abnormal_protection,
                      gate_short_protection, gate_open_protection,
                      feedback_open_loop_protection, overvoltage_flag, overload_flag};
  assign status_word = flag_word;
  // unmapped addresses read as zero
  assign nxt_rdata = !rd_stb ? '0 :
                     (addr == `REG_CTRL) ? ctrl_ff :
                     (addr == `REG_STATUS) ? status_word :
                     (addr == `REG_CAUSE) ? cause_ff : '0;

  // control survives lockout: software setup is not supply-bound
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RESET;
      rdata_ff <= '0;
    end else begin
      if (wr_stb && addr == `REG_CTRL) begin
        ctrl_ff <= wdata;
      end
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata = rdata_ff;

  // ============================================================
  // delay filters: sense overload, comp overload, overvoltage, open loop
  localparam int NF = 4;
  wire logic [NF-1:0] f_cond;
  wire logic [NF-1:0] f_hit;
  localparam prot_pkg::cnt_t F_LIM [NF] = '{
    prot_pkg::cnt_t'(`CYC_UP(`OLP_DELAY_NS)),
    prot_pkg::cnt_t'(`CYC_UP(`OLP_DELAY_NS)),
    prot_pkg::cnt_t'(`CYC_UP(`OVP_DELAY_NS)),
    prot_pkg::cnt_t'(`CYC_UP(`FBO_VALID_NS))
  };

  assign f_cond[0] = sense_over_olp & ctrl_ff[`CTRL_SENSE_BIT];
  assign f_cond[1] = comp_over_fsmax & ctrl_ff[`CTRL_COMP_BIT];
  assign f_cond[2] = fb_over_ovp;
  assign f_cond[3] = vdd_above_rdy & fb_below_open;

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_filt
      prot_pkg::cnt_t cnt_ff;
      prot_pkg::cnt_t nxt_cnt;
      // restart whenever the condition drops before expiry
      assign nxt_cnt = (!sup_on || !f_cond[gi]) ? '0 :
                       (cnt_ff == F_LIM[gi]) ? cnt_ff : cnt_ff + 1'b1;
      assign f_hit[gi] = f_cond[gi] && (cnt_ff == F_LIM[gi]);
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          cnt_ff <= '0;
        end else begin
          cnt_ff <= nxt_cnt;
        end
      end
    end
  endgenerate

  // ============================================================
  // rectifier gate-open cycle counting
  logic gate_d_ff;
  logic good_ff;
  logic [3:0] gop_cnt_ff;
  logic [3:0] nxt_gop_cnt;
  wire logic gate_end;
  wire logic good_now;
  wire logic gop_hit;

  assign gate_end = gate_d_ff & ~rectifier_gate_drive;
  assign good_now = good_ff | (rectifier_gate_drive & drain_above_gate_open);
  // any good cycle restarts the consecutive count
  assign nxt_gop_cnt = !sup_on ? '0 :
                       !gate_end ? gop_cnt_ff :
                       good_now ? '0 : gop_cnt_ff + 1'b1;
  assign gop_hit = gate_end && !good_now && (gop_cnt_ff == `GATE_OPEN_CYCLES - 1'b1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_d_ff <= 1'b0;
      good_ff <= 1'b0;
      gop_cnt_ff <= '0;
    end else begin
      gate_d_ff <= rectifier_gate_drive & sup_on;
      good_ff <= sup_on & rectifier_gate_drive & good_now;
      gop_cnt_ff <= nxt_gop_cnt;
    end
  end

  // ============================================================
  // drain-abnormal pulse counting
  logic [4:0] pulse_cnt_ff;
  logic [4:0] nxt_pulse_cnt;
  logic rearm_ff;
  logic nxt_rearm;
  wire logic pulse_hit;

  // a drain-triggered gate in the same cycle as a pulse counts as good
  assign nxt_pulse_cnt = (!sup_on || drain_trigger) ? '0 :
                         (primary_switch_pulse && pulse_cnt_ff != `DRAIN_PULSES) ?
                         pulse_cnt_ff + 1'b1 : pulse_cnt_ff;
  assign pulse_hit = sup_on && !drain_trigger && primary_switch_pulse &&
                     (pulse_cnt_ff == `DRAIN_PULSES - 1'b1);
  // after a primary lockout clear, wait for a valid drain signal
  assign nxt_rearm = sup_on &&
                     ((drain_abnormal_protection && primary_uvlo) ||
                      (rearm_ff && !drain_trigger));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_cnt_ff <= '0;
      rearm_ff <= 1'b0;
    end else begin
      pulse_cnt_ff <= nxt_pulse_cnt;
      rearm_ff <= nxt_rearm;
    end
  end

  // ============================================================
  // protection flags; all fall when the supply is locked out
  wire logic olp_set;
  wire logic nxt_olp;
  wire logic nxt_ovp;
  wire logic nxt_fbo;
  wire logic nxt_gop;
  wire logic nxt_gsp;
  wire logic nxt_dap;
  wire logic nxt_otp;
  wire logic any_flag;
  wire logic nxt_sw_en;

  assign olp_set = f_hit[0] | f_hit[1];
  assign nxt_olp = sup_on & latch_next(olp_set, primary_uvlo, overload_flag);
  assign nxt_ovp = sup_on & latch_next(f_hit[2], fb_at_ref, overvoltage_flag);
  assign nxt_fbo = sup_on & latch_next(f_hit[3], 1'b0, feedback_open_loop_protection);
  assign nxt_gop = sup_on & latch_next(gop_hit, primary_restart,
                                        gate_open_protection);
  // the gate pin is checked only at the turn-on moment
  assign nxt_gsp = latch_next(turn_on_evt & gate_low_resistance,
                              primary_restart | !sup_on, gate_short_protection);
  assign nxt_dap = sup_on & latch_next(pulse_hit, primary_uvlo,
                                       drain_abnormal_protection);
  assign nxt_otp = sup_on & latch_next(temp_over_trip, temp_below_release,
                                        secondary_overtemp_flag);
  assign any_flag = nxt_olp | nxt_ovp | nxt_fbo | nxt_gop | nxt_gsp | nxt_dap | nxt_otp;
  assign nxt_sw_en = nxt_sup == prot_pkg::SUP_ON && !any_flag && !nxt_rearm;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overload_flag <= 1'b0;
      overvoltage_flag <= 1'b0;
      feedback_open_loop_protection <= 1'b0;
      gate_open_protection <= 1'b0;
      gate_short_protection <= 1'b0;
      drain_abnormal_protection <= 1'b0;
      secondary_overtemp_flag <= 1'b0;
    end else begin
      overload_flag <= nxt_olp;
      overvoltage_flag <= nxt_ovp;
      feedback_open_loop_protection <= nxt_fbo;
      gate_open_protection <= nxt_gop;
      gate_short_protection <= nxt_gsp;
      drain_abnormal_protection <= nxt_dap;
      secondary_overtemp_flag <= nxt_otp;
    end
  end

  // first-cause capture for software, cleared at lockout
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cause_ff <= '0;
    end else if (!sup_on) begin
      cause_ff <= '0;
    end else if (cause_ff == '0) begin
      cause_ff <= {1'b0, flag_word[6:0]};
    end
  end

  // ============================================================
  // outputs and the primary drive flip-flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      controller_active <= 1'b0;
      switching_enable <= 1'b0;
      comp_short_to_ground <= 1'b0;
      bleed_current_enable <= 1'b0;
      primary_gate_drive <= 1'b0;
    end else begin
      controller_active <= nxt_sup == prot_pkg::SUP_ON;
      switching_enable <= nxt_sw_en;
      comp_short_to_ground <= nxt_olp | nxt_dap;
      bleed_current_enable <= nxt_ovp;
      // reset dominates so a late set cannot extend the pulse
      if (peak_cmp || !nxt_sw_en) begin
        primary_gate_drive <= 1'b0;
      end else if (drive_set) begin
        primary_gate_drive <= 1'b1;
      end
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_supply_qualify: assert property (
    $rose(controller_active) |-> $past(vdd_above_on, 2) && $past(vdd_above_on, 8))
    else $error("supply turned on without qualified comparator");
  chk_lockout_clear: assert property (
    !sup_on |=> !overload_flag && !drain_abnormal_protection && !gate_open_protection)
    else $error("flag survived supply lockout");
  chk_overload_hold: assert property (
    overload_flag && sup_on && !primary_uvlo && nxt_sup == prot_pkg::SUP_ON
    |=> overload_flag)
    else $error("overload flag dropped without lockout");
  chk_comp_ground: assert property (
    overload_flag |-> comp_short_to_ground)
    else $error("compensation not grounded during overload");
  chk_bleed_on: assert property (
    overvoltage_flag |-> bleed_current_enable)
    else $error("bleed off during overvoltage");
  chk_ovp_release: assert property (
    overvoltage_flag && fb_at_ref && !f_hit[2] |=> !overvoltage_flag)
    else $error("overvoltage not cleared at reference");
  chk_gate_open_hold: assert property (
    gate_open_protection && !primary_restart && sup_on && uv_want == 1'b0
    |=> gate_open_protection)
    else $error("gate-open cleared without restart");
  chk_sw_inhibit: assert property (
    (overload_flag || overvoltage_flag || drain_abnormal_protection)
    |-> !switching_enable)
    else $error("switching enabled with a flag set");
  chk_peak_reset: assert property (
    peak_cmp |=> !primary_gate_drive)
    else $error("drive not reset by peak comparator");
  chk_drain_count: assert property (
    $rose(drain_abnormal_protection) |-> $past(primary_switch_pulse))
    else $error("drain-abnormal set without a pulse");
  // latches that must ride out everything but their own clear and a supply lockout
  chk_gate_short_hold: assert property (
    gate_short_protection && sup_on && !primary_restart |=> gate_short_protection)
    else $error("gate short cleared without restart");
  chk_otp_hold: assert property (
    secondary_overtemp_flag && sup_on && !temp_below_release |=> secondary_overtemp_flag)
    else $error("over-temperature flag released early");
  chk_open_loop_hold: assert property (
    feedback_open_loop_protection && sup_on |=> feedback_open_loop_protection)
    else $error("open-loop flag dropped while supplied");
  chk_rearm_block: assert property (
    rearm_ff |-> !switching_enable)
    else $error("switching before a valid drain signal");
  chk_gate_open_count: assert property (
    $rose(gate_open_protection) |-> $past(gate_end) && !$past(good_now))
    else $error("gate-open set without a bad cycle end");
  chk_drive_enable: assert property (
    primary_gate_drive |-> switching_enable)
    else $error("primary drive high while switching inhibited");

  cov_overload: cover property ($rose(overload_flag));
  cov_drain_abn: cover property ($rose(drain_abnormal_protection));
  cov_gate_open: cover property ($rose(gate_open_protection));
  cov_gate_short: cover property ($rose(gate_short_protection));
  cov_ovp_cycle: cover property ($rose(overvoltage_flag) ##[1:200] $fell(overvoltage_flag));

endmodule : secondary_protection_supervisor

// file: verif/primary_side_model.sv
// behavioural model of the primary-side controller events seen by the supervisor
`timescale 1ns/1ns
module primary_side_model (
  input wire logic clock,
  output logic primary_switch_pulse,
  output logic drive_set,
  output logic primary_restart,
  output logic primary_uvlo,
  output logic drain_trigger
);
  // ==========
  // event pulses
  // all events idle low; each one is a single-cycle pulse launched after an edge
  initial begin
    {drain_trigger, primary_uvlo, primary_restart, drive_set, primary_switch_pulse} = 5'h00;
  end
  // mask bits: 0 switch pulse, 1 drive set, 2 restart, 3 uvlo, 4 drain trigger
  task automatic fire(input logic [4:0] m, input int n);
    repeat (n) begin
      @(posedge clock);
      {drain_trigger, primary_uvlo, primary_restart, drive_set, primary_switch_pulse} <= m;
      @(posedge clock);
      {drain_trigger, primary_uvlo, primary_restart, drive_set, primary_switch_pulse} <= 5'h00;
    end
  endtask : fire
endmodule : primary_side_model

// file: verif/tb.sv
// self-checking testbench for the secondary protection supervisor
`timescale 1ns/1ns
`include "prot_params.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb;
  localparam logic [4:0] ev_sw = 5'h01, ev_ds = 5'h02, ev_rs = 5'h04, ev_uv = 5'h08;
  localparam logic [4:0] ev_dt = 5'h10;
  logic clock, rst, wr_stb, rd_stb, vdd_above_on, vdd_below_off, vdd_above_rdy;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] wdata, rdata;
  logic sense_over_olp, comp_over_fsmax, fb_over_ovp, fb_at_ref, fb_below_open, peak_cmp;
  logic rectifier_gate_drive, drain_above_gate_open, gate_low_resistance, temp_over_trip;
  logic temp_below_release, primary_switch_pulse, drain_trigger, primary_restart;
  logic primary_uvlo, drive_set, controller_active, overload_flag, overvoltage_flag;
  logic feedback_open_loop_protection, gate_open_protection, gate_short_protection;
  logic drain_abnormal_protection, secondary_overtemp_flag, switching_enable;
  logic comp_short_to_ground, bleed_current_enable, primary_gate_drive;
  int failures, compares, cycles;

  secondary_protection_supervisor secondary_protection_supervisor_i (
    .clock, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .vdd_above_on, .vdd_below_off,
    .vdd_above_rdy, .sense_over_olp, .comp_over_fsmax, .fb_over_ovp, .fb_at_ref,
    .fb_below_open, .rectifier_gate_drive, .drain_above_gate_open, .gate_low_resistance,
    .primary_switch_pulse, .drain_trigger, .primary_restart, .primary_uvlo,
    .temp_over_trip, .temp_below_release, .drive_set, .peak_cmp, .controller_active,
    .overload_flag, .overvoltage_flag, .feedback_open_loop_protection,
    .gate_open_protection, .gate_short_protection, .drain_abnormal_protection,
    .secondary_overtemp_flag, .switching_enable, .comp_short_to_ground,
    .bleed_current_enable, .primary_gate_drive);
  primary_side_model primary_side_model_i (
    .clock, .primary_switch_pulse, .drive_set, .primary_restart, .primary_uvlo,
    .drain_trigger);

  // ==========
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // whole run needs about 15k cycles, so 30k only trips on a real hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      final_report();
    end
  end

  // ==========
  // access tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic reg_wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : reg_wr
  // read data are valid only in the cycle after the strobe
  task automatic reg_rd(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] exp);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : reg_rd
  // supply change held past qualification; checked just before and after 500 edges
  task automatic supply(input logic on);
    @(posedge clock);
    vdd_above_on <= on;
    vdd_below_off <= !on;
    cyc(497);
    `CHK(controller_active, !on)
    cyc(6);
    `CHK(controller_active, on)
  endtask : supply
  // one rectifier conduction cycle, ended by the gate falling
  task automatic sr_cycle(input logic good);
    @(posedge clock);
    rectifier_gate_drive <= 1'b1;
    drain_above_gate_open <= good;
    repeat (2) @(posedge clock);
    rectifier_gate_drive <= 1'b0;
    drain_above_gate_open <= 1'b0;
  endtask : sr_cycle
  task automatic final_report;
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // ==========
  // main sequence
  initial begin
    {rst, wr_stb, rd_stb, vdd_above_on, vdd_above_rdy, sense_over_olp} = 6'h20;
    {comp_over_fsmax, fb_over_ovp, fb_at_ref, fb_below_open, peak_cmp} = 5'h00;
    {rectifier_gate_drive, drain_above_gate_open, gate_low_resistance} = 3'h0;
    {temp_over_trip, temp_below_release, vdd_below_off} = 3'h1;
    addr = 2'h0;
    wdata = 8'h00;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cyc(1);
    `CHK(switching_enable, 1'b0)
    reg_rd(`REG_CTRL, 8'h03);
    reg_wr(`REG_STATUS, 8'hFF);
    reg_rd(`REG_CTRL, 8'h03);
    reg_rd(`REG_STATUS, 8'h00);
    reg_rd(2'h3, 8'h00);
    // short supply spike is ignored
    @(posedge clock);
    vdd_above_on <= 1'b1;
    vdd_below_off <= 1'b0;
    repeat (490) @(posedge clock);
    vdd_above_on <= 1'b0;
    cyc(20);
    `CHK(controller_active, 1'b0)
    supply(1'b1);
    primary_side_model_i.fire(ev_dt, 1);
    cyc(2);
    `CHK(switching_enable, 1'b1)
    // sense overload: disabled path first, then a full delay
    reg_wr(`REG_CTRL, 8'h02);
    @(posedge clock) sense_over_olp <= 1'b1;
    cyc(2510);
    `CHK(overload_flag, 1'b0)
    reg_wr(`REG_CTRL, 8'h03);
    cyc(2498);
    `CHK(overload_flag, 1'b0)
    cyc(6);
    `CHK(overload_flag, 1'b1)
    `CHK(switching_enable, 1'b0)
    `CHK(comp_short_to_ground, 1'b1)
    @(posedge clock) sense_over_olp <= 1'b0;
    cyc(50);
    `CHK(overload_flag, 1'b1)
    reg_rd(`REG_STATUS, 8'h81);
    reg_rd(`REG_CAUSE, 8'h01);
    primary_side_model_i.fire(ev_uv, 1);
    cyc(2);
    `CHK(overload_flag, 1'b0)
    `CHK(comp_short_to_ground, 1'b0)
    // compensation path, with an early drop restarting the timer
    @(posedge clock) comp_over_fsmax <= 1'b1;
    repeat (2000) @(posedge clock);
    comp_over_fsmax <= 1'b0;
    @(posedge clock) comp_over_fsmax <= 1'b1;
    cyc(2498);
    `CHK(overload_flag, 1'b0)
    cyc(6);
    `CHK(overload_flag, 1'b1)
    @(posedge clock) comp_over_fsmax <= 1'b0;
    primary_side_model_i.fire(ev_uv | ev_dt, 1);
    cyc(2);
    `CHK(overload_flag, 1'b0)
    // overvoltage with bleed
    @(posedge clock) fb_over_ovp <= 1'b1;
    cyc(998);
    `CHK(overvoltage_flag, 1'b0)
    cyc(6);
    `CHK(overvoltage_flag, 1'b1)
    `CHK(bleed_current_enable, 1'b1)
    @(posedge clock) fb_over_ovp <= 1'b0;
    fb_at_ref <= 1'b1;
    cyc(3);
    `CHK(bleed_current_enable, 1'b0)
    `CHK(switching_enable, 1'b1)
    @(posedge clock) fb_at_ref <= 1'b0;
    // over-temperature latch
    @(posedge clock) temp_over_trip <= 1'b1;
    @(posedge clock) temp_over_trip <= 1'b0;
    cyc(3);
    `CHK(secondary_overtemp_flag, 1'b1)
    @(posedge clock) temp_below_release <= 1'b1;
    @(posedge clock) temp_below_release <= 1'b0;
    cyc(2);
    `CHK(secondary_overtemp_flag, 1'b0)
    // gate open: a good cycle restarts the count of bad cycles
    repeat (7) sr_cycle(1'b0);
    sr_cycle(1'b1);
    repeat (7) sr_cycle(1'b0);
    cyc(3);
    `CHK(gate_open_protection, 1'b0)
    sr_cycle(1'b0);
    cyc(20);
    `CHK(gate_open_protection, 1'b1)
    primary_side_model_i.fire(ev_rs, 1);
    cyc(2);
    `CHK(gate_open_protection, 1'b0)
    // drain abnormal after 17 unanswered pulses
    primary_side_model_i.fire(ev_sw, 16);
    primary_side_model_i.fire(ev_dt, 1);
    primary_side_model_i.fire(ev_sw, 16);
    cyc(2);
    `CHK(drain_abnormal_protection, 1'b0)
    primary_side_model_i.fire(ev_sw, 1);
    cyc(2);
    `CHK(drain_abnormal_protection, 1'b1)
    `CHK(comp_short_to_ground, 1'b1)
    primary_side_model_i.fire(ev_uv, 1);
    cyc(2);
    `CHK({drain_abnormal_protection, switching_enable}, 2'h0)
    primary_side_model_i.fire(ev_dt, 1);
    cyc(2);
    `CHK(switching_enable, 1'b1)
    // peak comparator ends the primary drive
    primary_side_model_i.fire(ev_ds, 1);
    cyc(1);
    `CHK(primary_gate_drive, 1'b1)
    @(posedge clock) peak_cmp <= 1'b1;
    @(posedge clock) peak_cmp <= 1'b0;
    cyc(3);
    `CHK(primary_gate_drive, 1'b0)
    // open loop, cleared by lockout, then a shorted gate at turn-on
    @(posedge clock) vdd_above_rdy <= 1'b1;
    fb_below_open <= 1'b1;
    cyc(1998);
    `CHK(feedback_open_loop_protection, 1'b0)
    cyc(6);
    `CHK(feedback_open_loop_protection, 1'b1)
    @(posedge clock) fb_below_open <= 1'b0;
    gate_low_resistance <= 1'b1;
    supply(1'b0);
    `CHK(feedback_open_loop_protection, 1'b0)
    supply(1'b1);
    `CHK(gate_short_protection, 1'b1)
    `CHK(switching_enable, 1'b0)
    @(posedge clock) gate_low_resistance <= 1'b0;
    primary_side_model_i.fire(ev_rs, 1);
    cyc(2);
    `CHK(gate_short_protection, 1'b0)
    final_report();
  end
endmodule : tb
